// *** src/ctt_defs.svh ***
// Register offsets, field positions and reset values of the capture time-base timers
`ifndef CTT_DEFS_SVH
`define CTT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CTT_ADR_CTRL_U1   8'h00
`define CTT_ADR_CTRL_U2   8'h04
`define CTT_ADR_TMR_BASE  8'h08
`define CTT_ADR_REL_BASE  8'h18

// ----------------------------------------------------------------------------
// Control field layout, per byte of a control register
// ----------------------------------------------------------------------------
`define CTT_SEL_LSB       0
`define CTT_MODE_BIT      3
`define CTT_RUN_BIT       6
`define CTT_HALF          8
`define CTT_CTRL_MASK     16'h4f4f

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define CTT_CTRL_RST      16'h0000
`define CTT_TMR_RST       16'h0000
`define CTT_REL_RST       16'h0000
`define CTT_PRESC_ALL     10'h3ff
`define CTT_SEL_MAX       3'h7

`endif

// *** src/ctt_pkg.sv ***
// Types shared by the capture time-base timer design
package ctt_pkg;

    typedef logic [2:0] ctt_sel_t;

    // Pin synchroniser and edge history
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } ctt_edge_s;

    // Top-level state
    typedef struct packed {
        logic [1:0][15:0] ctrl;
        logic [3:0][15:0] rel;
        logic [9:0]       presc;
        logic [1:0]       sec_dly;
        logic             ack;
        logic [31:0]      dat;
    } ctt_top_s;

endpackage

// *** src/ctt_pin_edge.sv ***
// Count pin synchroniser with rise and fall detection
`timescale 1ns/10ps
`default_nettype none

module ctt_pin_edge
    import ctt_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin level and detected edges
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);
    import ctt_pkg::*;

    ctt_edge_s st_r;
    ctt_edge_s st_nxt;

    // Two flops before any logic; edges compare the last two settled samples
    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Levels held 8 clocks are never missed by this sampler
    assign rise_o = st_r.s2 & ~st_r.prev;
    assign fall_o = ~st_r.s2 & st_r.prev;

endmodule // ctt_pin_edge

`default_nettype wire

// *** src/ctt_timer.sv ***
// One up-counting time-base timer with reload on overflow
`timescale 1ns/10ps
`default_nettype none

module ctt_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Count control
    input  wire logic             run_i,
    input  wire logic             pulse_i,
    input  wire logic [WIDTH-1:0] reload_i,
    // Software write
    input  wire logic             wr_en_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // State
    output logic      [WIDTH-1:0] value_o,
    output logic                  ovf_o
);
    import ctt_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             ovf;
    } ctt_tmr_s;

    ctt_tmr_s st_r;
    ctt_tmr_s st_nxt;

    // Elaboration-time refusal: a one-bit counter has no room between a step and a reload
    if (WIDTH < 2) begin : g_width_check
        $error("ctt_timer: WIDTH must be at least 2");
    end

    always_comb begin
        st_nxt     = st_r;
        st_nxt.ovf = 1'b0;
        if (wr_en_i) begin
            // Software write wins; the pending step is dropped
            st_nxt.cnt = wr_data_i;
        end else if (run_i && pulse_i) begin
            if (&st_r.cnt) begin
                st_nxt.cnt = reload_i;
                st_nxt.ovf = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_o = st_r.cnt;
    assign ovf_o   = st_r.ovf;

endmodule // ctt_timer

`default_nettype wire

// *** src/ctt_top.sv ***
// Capture unit time-base timers: four timers, two per unit, behind a Wishbone slave
`timescale 1ns/10ps
`default_nettype none

`include "ctt_defs.svh"

module ctt_top
    import ctt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Count sources
    input  wire logic        unit1_count_pin_i,
    input  wire logic        unit2_count_pin_i,
    input  wire logic        companion_ovf_i,
    // Overflow pulses, one per timer
    output logic      [3:0]  timer_ovf_o
);
    import ctt_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Tick when the low (select+3) prescaler bits are all ones
    function automatic logic presc_tick(input ctt_sel_t sel, input logic [9:0] p);
        logic [9:0] mask;
        mask       = `CTT_PRESC_ALL >> (`CTT_SEL_MAX - sel);
        presc_tick = ((p & mask) == mask);
    endfunction

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            res[15:8] = new_v[15:8];
        end
        merge16 = res;
    endfunction

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    ctt_top_s          st_r;
    ctt_top_s          st_nxt;

    logic [1:0]        pin_rise;
    logic [1:0]        pin_fall;
    logic [3:0][15:0]  tmr_val;
    logic [3:0]        tmr_wr;
    logic [3:0][15:0]  tmr_wdat;
    logic [3:0]        tmr_pulse;
    logic [3:0]        raw_pulse;
    logic [3:0]        tmr_run;
    logic              take;

    assign take = wb_cyc_i & wb_stb_i & ~st_r.ack;

    // ------------------------------------------------------------------------
    // Count pins
    // ------------------------------------------------------------------------
    ctt_pin_edge u_edge_u1 (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (unit1_count_pin_i),
        .rise_o (pin_rise[0]),
        .fall_o (pin_fall[0])
    );

    ctt_pin_edge u_edge_u2 (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (unit2_count_pin_i),
        .rise_o (pin_rise[1]),
        .fall_o (pin_fall[1])
    );

    // ------------------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------------------
    // Timer k: unit k/2, secondary when k is odd
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            logic [7:0] cb;
            ctt_sel_t   sel;
            cb           = (k % 2 == 1) ? st_r.ctrl[k/2][15:8] : st_r.ctrl[k/2][7:0];
            sel          = cb[`CTT_SEL_LSB +: 3];
            tmr_run[k]   = cb[`CTT_RUN_BIT];
            raw_pulse[k] = 1'b0;
            if (!cb[`CTT_MODE_BIT]) begin
                // Shared free-running prescaler: first step comes within one period
                raw_pulse[k] = presc_tick(sel, st_r.presc);
            end else if (k % 2 == 0) begin
                unique case (sel)
                    3'h0:    raw_pulse[k] = companion_ovf_i;
                    3'h1:    raw_pulse[k] = pin_rise[k/2];
                    3'h2:    raw_pulse[k] = pin_fall[k/2];
                    3'h3:    raw_pulse[k] = pin_rise[k/2] | pin_fall[k/2];
                    default: raw_pulse[k] = 1'b0;
                endcase
            end else begin
                raw_pulse[k] = (sel == 3'h0) ? companion_ovf_i : 1'b0;
            end
        end
    end

    // Secondary timers step one clock late, so a shared moment favours the primary
    always_comb begin
        tmr_pulse[0] = raw_pulse[0];
        tmr_pulse[1] = st_r.sec_dly[0];
        tmr_pulse[2] = raw_pulse[2];
        tmr_pulse[3] = st_r.sec_dly[1];
    end

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_tmr
        ctt_timer #(
            .WIDTH (16)
        ) u_tmr (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .run_i     (tmr_run[g]),
            .pulse_i   (tmr_pulse[g]),
            .reload_i  (st_r.rel[g]),
            .wr_en_i   (tmr_wr[g]),
            .wr_data_i (tmr_wdat[g]),
            .value_o   (tmr_val[g]),
            .ovf_o     (timer_ovf_o[g])
        );
    end

    // ------------------------------------------------------------------------
    // Register bus and state update
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt         = st_r;
        st_nxt.presc   = st_r.presc + 10'h001;
        // Delay only steps seen while running; a tick just before run would put the secondary ahead
        st_nxt.sec_dly = {raw_pulse[3] & tmr_run[3], raw_pulse[1] & tmr_run[1]};
        // One-cycle ack, dropped the cycle after it was given
        st_nxt.ack     = take;
        tmr_wr         = '0;
        for (int k = 0; k < 4; k++) begin
            tmr_wdat[k] = merge16(tmr_val[k], wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        if (take) begin
            st_nxt.dat = 32'h0000_0000;
            for (int u = 0; u < 2; u++) begin
                if (wb_adr_i == (`CTT_ADR_CTRL_U1 + 8'(4 * u))) begin
                    st_nxt.dat[15:0] = st_r.ctrl[u] & `CTT_CTRL_MASK;
                    if (wb_we_i) begin
                        st_nxt.ctrl[u] = merge16(st_r.ctrl[u], wb_dat_i[15:0], wb_sel_i[1:0])
                                         & `CTT_CTRL_MASK;
                    end
                end
            end
            for (int k = 0; k < 4; k++) begin
                if (wb_adr_i == (`CTT_ADR_TMR_BASE + 8'(4 * k))) begin
                    st_nxt.dat[15:0] = tmr_val[k];
                    tmr_wr[k]        = wb_we_i;
                end
                if (wb_adr_i == (`CTT_ADR_REL_BASE + 8'(4 * k))) begin
                    st_nxt.dat[15:0] = st_r.rel[k];
                    if (wb_we_i) begin
                        st_nxt.rel[k] = merge16(st_r.rel[k], wb_dat_i[15:0], wb_sel_i[1:0]);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.ctrl    <= {`CTT_CTRL_RST, `CTT_CTRL_RST};
            st_r.rel     <= {4{`CTT_REL_RST}};
            st_r.presc   <= '0;
            st_r.sec_dly <= '0;
            st_r.ack     <= 1'b0;
            st_r.dat     <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;

endmodule // ctt_top

`default_nettype wire

// *** tb/ctt_top_chk.sv ***
// Bus and overflow checker for the capture time-base timers
`timescale 1ns/10ps
`default_nettype none

module ctt_top_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Overflow pulses
    input wire logic [3:0]  timer_ovf_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack did not follow a taken request");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_dat_holds: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
        else $error("read data changed without access");
    a_reset_quiet: assert property ($fell(rst_i) |-> timer_ovf_o == 4'h0 && !wb_ack_o)
        else $error("outputs active right after reset");
    a_ovf_gap_pri: assert property (timer_ovf_o[0] |=> !timer_ovf_o[0] [*7])
        else $error("primary overflows too close");
    a_ovf_gap_sec: assert property (timer_ovf_o[1] |=> !timer_ovf_o[1] [*7])
        else $error("secondary overflows too close");
    a_ovf_gap_evt: assert property (timer_ovf_o[2] |=> !timer_ovf_o[2] [*7])
        else $error("event timer overflows too close");
endmodule // ctt_top_chk

bind ctt_top ctt_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_ovf_o(timer_ovf_o));

`default_nettype wire

// *** tb/ctt_src_model.sv ***
// Count pin and companion overflow source for the timer bench
`timescale 1ns/10ps
`default_nettype none

module ctt_src_model (
    // Clock
    input  wire logic clk_i,
    // Sources
    output logic      pin1_o,
    output logic      pin2_o,
    output logic      comp_o
);
    initial begin
        pin1_o = 1'b0;
        pin2_o = 1'b0;
        comp_o = 1'b0;
    end

    // Each level held 9 clocks so the synchroniser never loses an edge
    task automatic pins_toggle(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin1_o <= ~pin1_o;
            pin2_o <= ~pin2_o;
            repeat (8) @(posedge clk_i);
        end
    endtask

    task automatic comp_pulse();
        @(posedge clk_i);
        comp_o <= 1'b1;
        @(posedge clk_i);
        comp_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // ctt_src_model

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the capture time-base timers
`timescale 1ns/10ps
`default_nettype none

`include "ctt_defs.svh"

module tb_top;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pin1;
    logic        pin2;
    logic        comp;
    logic [3:0]  timer_ovf_o;
    logic [15:0] rd;
    int          gap;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // Event rows: control byte, preset, expected primary, expected secondary
    logic [7:0]  ctl [8] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h08, 8'h49, 8'h48};
    logic [15:0] pre [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff};
    logic [15:0] epri [8] = '{16'h2, 16'h2, 16'h2, 16'h4, 16'h0, 16'h0, 16'h1235, 16'h1235};
    logic [15:0] esec [8] = '{16'h2, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff, 16'h0abd};
    int          ovf_u2p = 0;
    int          ovf_u2s = 0;

    ctt_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unit1_count_pin_i(pin1),
        .unit2_count_pin_i(pin2), .companion_ovf_i(comp), .timer_ovf_o(timer_ovf_o));
    ctt_src_model u_src (.clk_i(clk_i), .pin1_o(pin1), .pin2_o(pin2), .comp_o(comp));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Hang guard, well above the roughly 10k cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            wrap_up();
        end
    end

    // Unit 2 overflow pulses as the design shows them
    always @(posedge clk_i) begin
        if (timer_ovf_o[2] === 1'b1) begin
            ovf_u2p <= ovf_u2p + 1;
        end
        if (timer_ovf_o[3] === 1'b1) begin
            ovf_u2s <= ovf_u2s + 1;
        end
    end

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h3;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h3;
        wb_dat_i = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, `CTT_ADR_CTRL_U2, 16'h0);
        check("control reset", rd, `CTT_CTRL_RST);
        wb_xfer(1'b1, 8'h30, 16'hffff);
        wb_xfer(1'b0, 8'h30, 16'h0);
        check("unmapped read", rd, 16'h0000);
        wb_xfer(1'b1, `CTT_ADR_CTRL_U2, 16'hb7b7);
        wb_xfer(1'b0, `CTT_ADR_CTRL_U2, 16'h0);
        check("control mask", rd, 16'h0707);
        // Timer mode: every prescaler choice, both unit 1 timers, secondary one clock behind
        for (int s = 0; s < 8; s++) begin
            wb_xfer(1'b1, `CTT_ADR_CTRL_U1, 16'h0);
            for (int t = 0; t < 2; t++) begin
                wb_xfer(1'b1, `CTT_ADR_TMR_BASE + 8'(4 * t), 16'hfffe);
                wb_xfer(1'b1, `CTT_ADR_REL_BASE + 8'(4 * t), 16'hfffe);
            end
            wb_xfer(1'b1, `CTT_ADR_CTRL_U1, {2{8'h40 | 8'(s)}});
            do @(posedge clk_i); while (timer_ovf_o[0] !== 1'b1);
            @(posedge clk_i);
            check("secondary one clock later", {15'h0, timer_ovf_o[1]}, 16'h1);
            gap = 1;
            do begin
                @(posedge clk_i);
                gap++;
            end while (timer_ovf_o[0] !== 1'b1);
            check("overflow period", 16'(gap), 16'(16 << s));
            wb_xfer(1'b0, `CTT_ADR_TMR_BASE, 16'h0);
            check("reloaded value", rd, 16'hfffe);
        end
        // Event mode on unit 2: select codes 0 to 4, run off, and reload
        wb_xfer(1'b1, `CTT_ADR_REL_BASE + 8'h08, 16'h1234);
        wb_xfer(1'b1, `CTT_ADR_REL_BASE + 8'h0c, 16'h0abc);
        for (int r = 0; r < 8; r++) begin
            wb_xfer(1'b1, `CTT_ADR_CTRL_U2, 16'h0);
            wb_xfer(1'b1, `CTT_ADR_TMR_BASE + 8'h08, pre[r]);
            wb_xfer(1'b1, `CTT_ADR_TMR_BASE + 8'h0c, pre[r]);
            wb_xfer(1'b1, `CTT_ADR_CTRL_U2, {2{ctl[r]}});
            u_src.pins_toggle(4);
            u_src.comp_pulse();
            u_src.comp_pulse();
            wb_xfer(1'b0, `CTT_ADR_TMR_BASE + 8'h08, 16'h0);
            check("unit2 primary count", rd, epri[r]);
            wb_xfer(1'b0, `CTT_ADR_TMR_BASE + 8'h0c, 16'h0);
            check("unit2 secondary count", rd, esec[r]);
        end
        // Timer write taken at the edge of a companion step: the write wins
        fork
            u_src.comp_pulse();
            wb_xfer(1'b1, `CTT_ADR_TMR_BASE + 8'h08, 16'h0100);
        join
        wb_xfer(1'b0, `CTT_ADR_TMR_BASE + 8'h08, 16'h0);
        check("write beats step", rd, 16'h0100);
        wb_xfer(1'b0, `CTT_ADR_TMR_BASE + 8'h0c, 16'h0);
        check("secondary still steps", rd, 16'h0abe);
        check("unit2 primary overflows", 16'(ovf_u2p), 16'h0002);
        check("unit2 secondary overflows", 16'(ovf_u2s), 16'h0001);
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
